// ### fifo_cascade_stage.sv
/*
  one fifo stage usable alone, in a token-ring depth chain, or in a
  fall-through data chain. in fall-through, empty_flag_n is output ready
  and full_flag_n is input ready, both active low, so stages chain pin to pin.
  in token-ring mode only the token holder stores or delivers words.
  limitation: read, write and transfer clocks are all the one clk_sys.
  assumes neighbours share clk_sys; write/read enables come from same-clock logic.
*/
// How it works
// - first chain device straps first-load low
// - other chain devices strap first-load high
// - write-token out feeds next write-token in
// - read-token out feeds next read-token in
// - all offset-load inputs share one signal
// - half-full stays inactive in token-ring mode
// - user ORs each flag across all devices
// - token-ring flags: one register stage
// - chained fall-through stages add capacities
// - every chained device strapped fall-through at reset
// - first word ripples down without reads
// - word on outputs drives output-ready low
// - ripple latency within per-device budget
// - only first word sees ripple delay
// - free slot drives input-ready low
// - bubble-up latency within per-device budget
// - transfer clock is the faster clock
// - skew misses may add handshake cycles
// - fall-through strap is 0,0,1 or 1,0,1
`timescale 1ns/10ps
`default_nettype none
module fifo_cascade_stage
  import fifo_cascade_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = DEF_DEPTH,
  parameter int AE_OFS = DEF_AE_OFS,
  parameter int AF_OFS = DEF_AF_OFS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // pins toward the outside party
  fifo_pins_if.dev pins
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 2);
  localparam logic [CW-1:0] CAP_STD = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_FT = CW'(DEPTH + 1);
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic cfg_done_r;
  cas_mode_type mode_r;
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CW-1:0] mem_cnt_r;
  logic out_vld_r;
  logic wtok_r;
  logic rtok_r;
  logic ofs_sel_r;
  logic [CW-1:0] ae_ofs_r;
  logic [CW-1:0] af_ofs_r;
  logic [WIDTH-1:0] data_out_r;
  logic full_r;
  logic ef_n_r;
  logic ff_n_r;
  logic ae_n_r;
  logic af_n_r;
  logic hf_n_r;
  logic wtok_out_r;
  logic rtok_out_r;

  wire [2:0] strap = {pins.first_load_sel, pins.read_token_in, pins.write_token_in};
  cas_mode_type strap_m;
  assign strap_m = strap_mode(strap);
  wire fall_through_mode = (mode_r == MODE_FALL_THROUGH_MODE);
  wire daisy = (mode_r == MODE_DAISY);
  // an offset load takes the write strobe but never stores a word
  wire ofs_wr = cfg_done_r && !pins.offset_load_n && !pins.wr_en_n;
  // full_r is the registered input ready, so both ends see the same handshake edge
  wire wr_go = cfg_done_r && pins.offset_load_n && !pins.wr_en_n && !full_r && (!daisy || wtok_r);
  wire mem_has = (mem_cnt_r != '0);
  wire rd_std = cfg_done_r && !fall_through_mode && !pins.rd_en_n && mem_has && (!daisy || rtok_r);
  wire rd_out = cfg_done_r && fall_through_mode && !pins.rd_en_n && out_vld_r;
  // fall-through refills the output word with no read request
  wire load_out = fall_through_mode && mem_has && (!out_vld_r || rd_out);
  wire mem_rd = rd_std || load_out;
  wire [CW-1:0] cnt_nxt = mem_cnt_r + CW'(wr_go) - CW'(mem_rd);
  wire vld_nxt = load_out ? 1'b1 : (rd_out ? 1'b0 : out_vld_r);
  wire [CW-1:0] total_nxt = cnt_nxt + CW'(vld_nxt);
  // output stage adds one word of capacity per device
  wire [CW-1:0] cap = fall_through_mode ? CAP_FT : CAP_STD;
  wire empty_nxt = fall_through_mode ? !vld_nxt : (cnt_nxt == '0);
  wire full_nxt = (total_nxt == cap);
  wire wtok_pass = daisy && wr_go && (wptr_r == LAST_LOC);
  wire rtok_pass = daisy && rd_std && (rptr_r == LAST_LOC);
  // before the strap edge the strap itself picks the ready polarity,
  // so no false output ready shows up once the strap edge has passed
  // (flags still hold their reset levels during that first cycle)
  wire ft_flags = cfg_done_r ? fall_through_mode : (strap_m == MODE_FALL_THROUGH_MODE);
  wire ef_pin_nxt = ft_flags ? empty_nxt : !empty_nxt;
  wire ff_pin_nxt = ft_flags ? full_nxt : !full_nxt;

  // mode straps caught at the first edge after reset release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_done_r <= 1'b0;
      mode_r <= MODE_SINGLE;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      mode_r <= strap_m;
    end
  end

  // storage is not reset: data_out is unknown until the first load
  always_ff @(posedge clk_sys) begin
    if (wr_go) begin
      mem[wptr_r] <= pins.data_in;
    end
    if (mem_rd) begin
      data_out_r <= mem[rptr_r];
    end
  end

  // pointers wrap at a power of two, so DEPTH must be one
  // later words stream behind the first with no added delay
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      mem_cnt_r <= '0;
      out_vld_r <= 1'b0;
    end else begin
      wptr_r <= wptr_r + AW'(wr_go);
      rptr_r <= rptr_r + AW'(mem_rd);
      mem_cnt_r <= cnt_nxt;
      out_vld_r <= vld_nxt;
    end
  end

  // token ring: holder accepts accesses, passes on at last location
  // a broken ring leaves no holder, and every read and write is then dropped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wtok_r <= 1'b0;
      rtok_r <= 1'b0;
      wtok_out_r <= 1'b1;
      rtok_out_r <= 1'b1;
    end else if (!cfg_done_r) begin
      wtok_r <= (strap_m == MODE_DAISY) && !pins.first_load_sel;
      rtok_r <= (strap_m == MODE_DAISY) && !pins.first_load_sel;
    end else begin
      wtok_r <= (daisy && !pins.write_token_in) || (wtok_r && !wtok_pass);
      rtok_r <= (daisy && !pins.read_token_in) || (rtok_r && !rtok_pass);
      wtok_out_r <= !wtok_pass;
      rtok_out_r <= !rtok_pass;
    end
  end

  // offset load: first write sets almost-empty, next sets almost-full
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ofs_sel_r <= 1'b0;
      ae_ofs_r <= CW'(AE_OFS);
      af_ofs_r <= CW'(AF_OFS);
    end else if (ofs_wr) begin
      ofs_sel_r <= !ofs_sel_r;
      if (ofs_sel_r) begin
        af_ofs_r <= pins.data_in[CW-1:0];
      end else begin
        ae_ofs_r <= pins.data_in[CW-1:0];
      end
    end
  end

  // every flag is one register stage from the occupancy update
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      full_r <= 1'b0;
      ef_n_r <= 1'b0;
      ff_n_r <= 1'b1;
      ae_n_r <= 1'b0;
      af_n_r <= 1'b1;
      hf_n_r <= 1'b1;
    end else begin
      // one clock only: no skew, so a ready never takes an extra cycle
      full_r <= full_nxt;
      ef_n_r <= ef_pin_nxt;
      ff_n_r <= ff_pin_nxt;
      ae_n_r <= (total_nxt > ae_ofs_r);
      af_n_r <= (total_nxt < cap - af_ofs_r);
      // no meaningful half point across a token ring
      hf_n_r <= daisy || (total_nxt <= HALF);
    end
  end

  assign pins.data_out = data_out_r;
  assign pins.empty_flag_n = ef_n_r;
  assign pins.full_flag_n = ff_n_r;
  assign pins.almost_empty_n = ae_n_r;
  assign pins.almost_full_n = af_n_r;
  assign pins.half_full_n = hf_n_r;
  assign pins.write_token_out = wtok_out_r;
  assign pins.read_token_out = rtok_out_r;
endmodule : fifo_cascade_stage
`default_nettype wire

// ### fifo_cascade_pkg.sv
/*
  shared constants for the cascaded fifo stage and its user-side controller.
  assumes one clock, clk_sys at 10 MHz; all strobes and the first-load strap are active low.
*/
`default_nettype none
package fifo_cascade_pkg;
  localparam int DATA_W = 18;
  localparam int DEF_DEPTH = 256;
  localparam int DEF_AE_OFS = 7;
  localparam int DEF_AF_OFS = 7;
  localparam int DEF_NDEV = 2;
  localparam int CLK_PERIOD_NS = 100;
  // per-device propagation budgets, in transfer-clock / edge-clock periods
  localparam int RIPPLE_XFER_CYC = 4;
  localparam int RIPPLE_READ_CYC = 3;
  localparam int BUBBLE_XFER_CYC = 3;
  localparam int BUBBLE_WRITE_CYC = 2;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_FALL_THROUGH_MODE = 2'b01,
    MODE_DAISY = 2'b11
  } cas_mode_type;

  // strap order: {first_load_sel, read_token_in, write_token_in}
  localparam logic [2:0] STRAP_DAISY_FIRST = 3'h3;
  localparam logic [2:0] STRAP_DAISY_OTHER = 3'h7;
  localparam logic [2:0] STRAP_FALL_THROUGH_MODE = 3'h5;
  localparam logic [2:0] STRAP_SINGLE = 3'h4;

  function automatic cas_mode_type strap_mode(input logic [2:0] s);
    if (s[1] && s[0]) strap_mode = MODE_DAISY;
    else if (!s[1] && s[0]) strap_mode = MODE_FALL_THROUGH_MODE;
    else strap_mode = MODE_SINGLE;
  endfunction : strap_mode

  function automatic logic [2:0] strap_for(input cas_mode_type m, input logic first);
    case (m)
      MODE_DAISY: strap_for = first ? STRAP_DAISY_FIRST : STRAP_DAISY_OTHER;
      MODE_FALL_THROUGH_MODE: strap_for = STRAP_FALL_THROUGH_MODE;
      default: strap_for = STRAP_SINGLE;
    endcase
  endfunction : strap_for
endpackage : fifo_cascade_pkg
`default_nettype wire

// ### fifo_pins_if.sv
/*
  pin set of one fifo stage toward its outside party.
  assumes the testbench ties token rings and data chains between instances.
*/
`timescale 1ns/10ps
`default_nettype none
interface fifo_pins_if #(parameter int WIDTH = 18);
  logic [WIDTH-1:0] data_in;
  logic wr_en_n;
  logic [WIDTH-1:0] data_out;
  logic rd_en_n;
  logic first_load_sel;
  logic write_token_in;
  logic read_token_in;
  logic write_token_out;
  logic read_token_out;
  logic offset_load_n;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_n;
  logic almost_full_n;
  logic half_full_n;

  modport dev (
    input data_in, wr_en_n, rd_en_n, first_load_sel, write_token_in, read_token_in, offset_load_n,
    output data_out, write_token_out, read_token_out, empty_flag_n, full_flag_n,
    output almost_empty_n, almost_full_n, half_full_n
  );
  modport ctl (
    output data_in, wr_en_n, rd_en_n, first_load_sel, write_token_in, read_token_in, offset_load_n,
    input data_out, write_token_out, read_token_out, empty_flag_n, full_flag_n,
    input almost_empty_n, almost_full_n, half_full_n
  );
endinterface : fifo_pins_if
`default_nettype wire

// ### fifo_cascade_user.sv
/*
  user-side party of one fifo stage: straps, shared offset load, write and
  read strobes, token relay and composite flags over the whole chain.
  assumes peers' flags and ring tokens arrive from same-clock logic.
*/
`timescale 1ns/10ps
`default_nettype none
module fifo_cascade_user
  import fifo_cascade_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int NDEV = DEF_NDEV,
  parameter cas_mode_type MODE = MODE_FALL_THROUGH_MODE,
  parameter bit FIRST = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // user write side
  input wire logic user_wr,
  input wire logic [WIDTH-1:0] user_wdata,
  input wire logic user_load_n,
  // user read side
  input wire logic user_rd,
  output logic [WIDTH-1:0] user_rdata,
  output logic user_rvalid,
  // ring tokens from the previous device, and ours toward the next
  input wire logic ring_wtok_in,
  input wire logic ring_rtok_in,
  output logic ring_wtok_out,
  output logic ring_rtok_out,
  // flags of the other devices in the chain
  input wire logic [NDEV-2:0] peer_empty_n,
  input wire logic [NDEV-2:0] peer_full_n,
  input wire logic [NDEV-2:0] peer_ae_n,
  input wire logic [NDEV-2:0] peer_af_n,
  // composite chain flags
  output logic all_empty_n,
  output logic all_full_n,
  output logic all_ae_n,
  output logic all_af_n,
  // pins of our stage
  fifo_pins_if.ctl pins
);
  localparam logic [2:0] STRAP = strap_for(MODE, FIRST);

  logic cfg_r;
  logic [2:0] strap_r;
  logic wr_n_r;
  logic rd_n_r;
  logic load_n_r;
  logic [WIDTH-1:0] wdata_r;
  logic rd_pend_r;
  logic [WIDTH-1:0] rdata_r;
  logic rvalid_r;
  logic wtok_o_r;
  logic rtok_o_r;
  logic [3:0] comp_r;

  // standard mode presents data the edge after the read; fall-through before it
  wire std_rd = (MODE != MODE_FALL_THROUGH_MODE);
  // fall-through output ready is active low
  wire rd_taken = !rd_n_r && (std_rd ? pins.empty_flag_n : !pins.empty_flag_n);
  // active-low flags: OR means low only when every device agrees
  wire c_empty = pins.empty_flag_n | (|peer_empty_n);
  wire c_full = pins.full_flag_n | (|peer_full_n);
  wire c_ae = pins.almost_empty_n | (|peer_ae_n);
  wire c_af = pins.almost_full_n | (|peer_af_n);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= 1'b0;
      strap_r <= STRAP;
    end else begin
      cfg_r <= 1'b1;
      // after the strap edge the token pins carry the ring
      strap_r <= {STRAP[2], (MODE != MODE_DAISY) | ring_rtok_in, (MODE != MODE_DAISY) | ring_wtok_in};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      load_n_r <= 1'b1;
      wdata_r <= '0;
    end else begin
      // strobes wait until the stage has caught its straps
      wr_n_r <= !(cfg_r && user_wr);
      rd_n_r <= !(cfg_r && user_rd);
      load_n_r <= user_load_n;
      wdata_r <= user_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_pend_r <= 1'b0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_taken && std_rd;
      rvalid_r <= std_rd ? rd_pend_r : rd_taken;
      if (std_rd ? rd_pend_r : rd_taken) begin
        rdata_r <= pins.data_out;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wtok_o_r <= 1'b1;
      rtok_o_r <= 1'b1;
      comp_r <= 4'h0;
    end else begin
      wtok_o_r <= pins.write_token_out;
      rtok_o_r <= pins.read_token_out;
      comp_r <= {c_empty, c_full, c_ae, c_af};
    end
  end

  assign pins.first_load_sel = strap_r[2];
  assign pins.read_token_in = strap_r[1];
  assign pins.write_token_in = strap_r[0];
  assign pins.wr_en_n = wr_n_r;
  assign pins.rd_en_n = rd_n_r;
  assign pins.offset_load_n = load_n_r;
  assign pins.data_in = wdata_r;
  assign user_rdata = rdata_r;
  assign user_rvalid = rvalid_r;
  assign ring_wtok_out = wtok_o_r;
  assign ring_rtok_out = rtok_o_r;
  assign all_empty_n = comp_r[3];
  assign all_full_n = comp_r[2];
  assign all_ae_n = comp_r[1];
  assign all_af_n = comp_r[0];
endmodule : fifo_cascade_user
`default_nettype wire

// ### fifo_depth_cascade_monitor.sv
/*
  concurrent checks on the pins between the user-side controller and one
  fall-through fifo stage.
  assumes the stage is strapped fall-through and everything runs on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module fifo_depth_cascade_monitor
  import fifo_cascade_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = DEF_DEPTH,
  parameter int AE_OFS = DEF_AE_OFS,
  parameter int AF_OFS = DEF_AF_OFS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // stage pins
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic offset_load_n,
  input wire logic [WIDTH-1:0] data_out,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n
);
  // output register adds one slot in fall-through
  localparam int CAP = DEPTH + 1;
  int occ_r;
  int occ_nxt;
  wire logic wr_take;
  wire logic rd_take;
  // fall-through readies are active low
  assign wr_take = !wr_en_n && offset_load_n && !full_flag_n;
  assign rd_take = !rd_en_n && !empty_flag_n;
  assign occ_nxt = occ_r + int'(wr_take) - int'(rd_take);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) occ_r <= 0;
    else occ_r <= occ_nxt;
  end

  // flags keep reset levels until the strap edge, so checks start after it
  logic [1:0] arm_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) arm_r <= 2'h0;
    else arm_r <= {arm_r[0], 1'b1};
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn || !arm_r[1]);

  a_first_word_ripple: assert property (wr_take && occ_r == 0 |-> ##[1:3] !empty_flag_n)
    else $error("first word did not reach the outputs in time");
  a_bubble_up_ready: assert property (full_flag_n && rd_take |-> ##[1:2] !full_flag_n)
    else $error("input ready late after read from full");
  a_word_holds: assert property (!empty_flag_n && rd_en_n |=> !empty_flag_n && $stable(data_out))
    else $error("output word changed without a read");
  a_no_phantom_word: assert property (empty_flag_n && wr_en_n && $past(wr_en_n) |=> empty_flag_n)
    else $error("output ready without a written word");
  a_full_exact: assert property (full_flag_n == (occ_r == CAP))
    else $error("full flag disagrees with stored word count");
  a_almost_empty_lvl: assert property (almost_empty_n == (occ_r > AE_OFS))
    else $error("almost-empty flag wrong for word count");
  a_almost_full_lvl: assert property (almost_full_n == (occ_r < CAP - AF_OFS))
    else $error("almost-full flag wrong for word count");
  a_full_has_word: assert property (full_flag_n |-> !empty_flag_n)
    else $error("full stage shows no output word");

  c_read_at_full: cover property (full_flag_n && rd_take);
  c_write_empty: cover property (wr_take && occ_r == 0);
  c_read_write: cover property (rd_take && wr_take);
endmodule : fifo_depth_cascade_monitor
`default_nettype wire

// ### fifo_depth_cascade_tb_top.sv
/*
  testbench: user-side controller facing one fall-through stage, with a
  queue model of the stored words and random peer flags.
  assumes a single clk_sys domain and the package constants.
*/
`timescale 1ns/10ps
`default_nettype none
module fifo_depth_cascade_tb_top;
  import fifo_cascade_pkg::*;
  // small depth keeps fill and drain short
  localparam int DEPTH = 16;
  localparam int CAP = DEPTH + 1;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic user_wr = 1'b0;
  logic [DATA_W-1:0] user_wdata = '0;
  logic user_rd = 1'b0;
  logic [DATA_W-1:0] user_rdata;
  logic user_rvalid;
  logic [0:0] peer_e = 1'b1;
  logic [0:0] peer_f = 1'b1;
  logic [0:0] peer_ae = 1'b1;
  logic [0:0] peer_af = 1'b1;
  logic all_e, all_f, all_ae, all_af;
  logic [3:0] comp_exp = 4'h0;
  logic comp_on = 1'b0;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 68011;
  int issued = 0;
  int got = 0;
  int g0;
  logic [31:0] rnd;
  logic [DATA_W-1:0] q[$];

  fifo_pins_if #(.WIDTH(DATA_W)) pins ();
  always #50 clk_sys = ~clk_sys;

  fifo_cascade_stage #(.DEPTH(DEPTH)) i_fifo_cascade_stage (.clk_sys(clk_sys), .rstn(rstn), .pins(pins));
  fifo_cascade_user #(.NDEV(2), .MODE(MODE_FALL_THROUGH_MODE), .FIRST(1'b1)) i_fifo_cascade_user (
    .clk_sys(clk_sys), .rstn(rstn), .user_wr(user_wr), .user_wdata(user_wdata), .user_load_n(1'b1),
    .user_rd(user_rd), .user_rdata(user_rdata), .user_rvalid(user_rvalid),
    .ring_wtok_in(1'b1), .ring_rtok_in(1'b1), .ring_wtok_out(), .ring_rtok_out(),
    .peer_empty_n(peer_e), .peer_full_n(peer_f), .peer_ae_n(peer_ae), .peer_af_n(peer_af),
    .all_empty_n(all_e), .all_full_n(all_f), .all_ae_n(all_ae), .all_af_n(all_af), .pins(pins));
  fifo_depth_cascade_monitor #(.DEPTH(DEPTH)) i_fifo_depth_cascade_monitor (
    .clk_sys(clk_sys), .rstn(rstn), .wr_en_n(pins.wr_en_n), .rd_en_n(pins.rd_en_n),
    .offset_load_n(pins.offset_load_n), .data_out(pins.data_out), .empty_flag_n(pins.empty_flag_n),
    .full_flag_n(pins.full_flag_n), .almost_empty_n(pins.almost_empty_n),
    .almost_full_n(pins.almost_full_n));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // refused words are sent but kept out of the model
  task automatic put(input logic [DATA_W-1:0] d, input bit keep);
    @(posedge clk_sys);
    user_wr <= 1'b1;
    user_wdata <= d;
    if (keep) begin
      q.push_back(d);
      issued++;
    end
  endtask : put

  task automatic idle(input int n);
    @(posedge clk_sys);
    user_wr <= 1'b0;
    user_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // read results and composite flags, one register late
  always @(posedge clk_sys) begin
    if (rstn && user_rvalid === 1'b1) begin
      if (q.size() == 0) check(18'h0, 18'h1);
      else check(user_rdata, q.pop_front());
      got++;
    end
    if (rstn && comp_on) check(18'({all_e, all_f, all_ae, all_af}), 18'(comp_exp));
    comp_exp = {pins.empty_flag_n | peer_e[0], pins.full_flag_n | peer_f[0],
                pins.almost_empty_n | peer_ae[0], pins.almost_full_n | peer_af[0]};
    comp_on = rstn;
    {peer_e, peer_f, peer_ae, peer_af} <= 4'($random(seed));
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    put(18'h2a5a5, 1'b1);
    idle(0);
    for (int i = 0; i < 8 && pins.empty_flag_n !== 1'b0; i++) @(posedge clk_sys);
    check(18'(pins.empty_flag_n), 18'h0);
    @(posedge clk_sys);
    user_rd <= 1'b1;
    idle(4);
    // overfill: words past capacity are lost
    for (int i = 0; i < CAP + 3; i++) put(18'(i * 3 + 1), i < CAP);
    idle(6);
    check(18'(pins.full_flag_n), 18'h1);
    @(posedge clk_sys);
    user_rd <= 1'b1;
    idle(4);
    check(18'(pins.full_flag_n), 18'h0);
    put(18'h3ffff, 1'b1);
    idle(5);
    check(18'(pins.full_flag_n), 18'h1);
    // back-to-back drain shows no added delay
    g0 = got;
    @(posedge clk_sys);
    user_rd <= 1'b1;
    repeat (CAP) @(posedge clk_sys);
    idle(4);
    check(18'(got - g0), 18'(CAP));
    repeat (400) begin
      rnd = $random(seed);
      if (rnd[0] && issued - got < CAP) put(18'(rnd >> 2), 1'b1);
      else begin
        @(posedge clk_sys);
        user_wr <= 1'b0;
      end
      user_rd <= rnd[1];
    end
    @(posedge clk_sys);
    user_wr <= 1'b0;
    user_rd <= 1'b1;
    repeat (CAP + 4) @(posedge clk_sys);
    idle(4);
    check(18'(q.size()), 18'h0);
    stop_test();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
endmodule : fifo_depth_cascade_tb_top
`default_nettype wire
